// ---- hdl/sap_pkg.sv ----
// Shared constants, types and slot helpers for the stereo serial audio port
package sap_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000; // Core clock rate
  localparam int FS_MAX_HZ = 50_000; // Highest frame rate allowed
  localparam int BITS_PER_FRAME = 64; // Bit clock is 64x frame rate
  // Half bit period in core cycles, rounded up so Fs never exceeds max
  localparam int BCLK_HALF_CYC = (CLK_HZ + 2 * BITS_PER_FRAME * FS_MAX_HZ
                                  - 1) / (2 * BITS_PER_FRAME * FS_MAX_HZ);
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_END = DIV_W'(BCLK_HALF_CYC - 1);

  // ------------------------------------------------------------------
  // Sample layout
  // ------------------------------------------------------------------
  localparam int SAMPLE_W = 24; // Widest sample word
  localparam int PAIR_W = 2 * SAMPLE_W; // Left in upper half
  localparam int SLOT_W = 6; // Slot counter over one frame half
  localparam logic [4:0] SAMPLE_MSB = 5'h17;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 6'h3F; // Reset slot value

  // ------------------------------------------------------------------
  // Register pointer
  // ------------------------------------------------------------------
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic AUTO_RST = 1'b0;
  localparam int PTR_AUTO_POS = 7;
  localparam int PTR_MSB = 2;
  localparam int PTR_LSB = 0;

  // Serial formats, in the order of their format numbers 0 to 3
  typedef enum logic [1:0] {
    SAP_I2S,
    SAP_LJ,
    SAP_RJ24,
    SAP_RJ20
  } sap_fmt_t;

  // Slot within a frame half that carries the sample MSB
  function automatic logic [SLOT_W-1:0] slot_start(sap_fmt_t f);
    logic [SLOT_W-1:0] s;
    s = 6'h00;
    unique case (f)
      SAP_I2S: s = 6'h01;
      SAP_LJ: s = 6'h00;
      SAP_RJ24: s = 6'h08;
      SAP_RJ20: s = 6'h0C;
    endcase
    return s;
  endfunction

  // Number of sample bits carried per channel
  function automatic logic [SLOT_W-1:0] slot_len(sap_fmt_t f);
    logic [SLOT_W-1:0] n;
    n = 6'h18;
    unique case (f)
      SAP_I2S, SAP_LJ, SAP_RJ24: n = 6'h18;
      SAP_RJ20: n = 6'h14;
    endcase
    return n;
  endfunction

endpackage

// ---- hdl/sap_if.sv ----
// Link wires between the codec end and the controller end
`timescale 1ns/100ps
interface sap_if;
  logic dev_bclk_o;
  logic dev_bclk_oe;
  logic dev_frame_o;
  logic dev_frame_oe;
  logic host_bclk_o;
  logic host_bclk_oe;
  logic host_frame_o;
  logic host_frame_oe;
  logic bit_clock;
  logic frame_clock;
  logic serial_sample_out;
  logic serial_sample_in;

  // Resolve the shared clock wires; an undriven wire reads low
  assign bit_clock = dev_bclk_oe ? dev_bclk_o :
                     (host_bclk_oe ? host_bclk_o : 1'b0);
  assign frame_clock = dev_frame_oe ? dev_frame_o :
                       (host_frame_oe ? host_frame_o : 1'b0);

  modport dev (
    output dev_bclk_o, dev_bclk_oe, dev_frame_o, dev_frame_oe,
    output serial_sample_out,
    input bit_clock, frame_clock, serial_sample_in
  );
  modport host (
    output host_bclk_o, host_bclk_oe, host_frame_o, host_frame_oe,
    output serial_sample_in,
    input bit_clock, frame_clock, serial_sample_out
  );
endinterface

// ---- hdl/sap_device.sv ----
// Codec end of the serial audio port: framing engine, buffer, pointer
`timescale 1ns/100ps

// How it works
// - format 0 is I2S, up to 24 bits
// - format 1 is left-justified, up to 24 bits
// - format 2 right-justified 24 bits, 64 Fs
// - format 3 right-justified 20 bits, 64 Fs
// - slave bit clock is 48, 64 or 128 Fs
// - slave master clock is 256/384/512 Fs
// - master bit clock always 64 Fs
// - register pointer resets to zero
// - master drives clocks, slave accepts them
// - pointer advances per byte when auto set
module sap_engine (
  input wire logic mclk, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire logic master, // High to drive the link clocks
  input wire sap_pkg::sap_fmt_t fmt, // Serial format
  input wire logic bclk_pin, // Bit clock level on the link
  input wire logic frame_pin, // Frame clock level on the link
  input wire logic sdi_pin, // Serial data from the far end
  output logic bclk_o, // Generated bit clock
  output logic bclk_oe, // Bit clock drive enable
  output logic frame_o, // Generated frame clock
  output logic frame_oe, // Frame clock drive enable
  output logic sdo_o, // Serial data to the far end
  input wire logic tx_valid, // Sample pair offered
  input wire logic [sap_pkg::PAIR_W-1:0] tx_data, // Left high, right low
  output logic tx_ready, // Pair accepted when valid
  output logic rx_valid, // Received pair available
  output logic [sap_pkg::PAIR_W-1:0] rx_data, // Left high, right low
  input wire logic rx_ready, // Consumer takes the pair
  output logic rx_overrun // Pulse: received pair dropped
);
  logic b_meta_q, b_sync_q, f_meta_q, f_sync_q, d_meta_q, d_sync_q;
  logic [sap_pkg::DIV_W-1:0] div_q;
  logic [sap_pkg::SLOT_W-1:0] gen_slot_q, gen_next;
  logic [sap_pkg::SLOT_W-1:0] slot_q, slot_d, start, len, k_tx, k_rx;
  logic bclk_lvl, frame_lvl, bclk_prev_q, frame_last_q, seen_q;
  logic fall, rise, left_lvl, is_left, new_half, tx_pop, rx_push;
  logic tx_bit_ok, rx_bit_ok, rx_in_ready, buf_tx_valid;
  logic [4:0] tx_idx, rx_idx;
  logic [sap_pkg::SAMPLE_W-1:0] tx_l_q, tx_r_q, tx_word, rx_l_q, rx_r_q;
  logic [sap_pkg::PAIR_W-1:0] buf_tx_data;

  // ------------------------------------------------------------------
  // Frame tracking
  // ------------------------------------------------------------------
  // Master works from its own clocks, slave from the synced pins
  assign bclk_lvl = bclk_oe ? bclk_o : b_sync_q;
  assign frame_lvl = frame_oe ? frame_o : f_sync_q;
  assign fall = bclk_prev_q & ~bclk_lvl;
  assign rise = ~bclk_prev_q & bclk_lvl;
  assign left_lvl = (fmt != sap_pkg::SAP_I2S);
  assign is_left = (frame_lvl == left_lvl);
  assign new_half = (frame_lvl != frame_last_q);
  // Slots count from each frame edge, so slave bit rates up to 128 Fs fit the 6-bit count
  assign slot_d = new_half ? 6'h00 : slot_q + 6'h01;
  assign start = sap_pkg::slot_start(fmt);
  assign len = sap_pkg::slot_len(fmt);
  assign k_tx = slot_d - start;
  assign k_rx = slot_q - start;
  // Right-justified starts put the LSB on slot 31, last of the half
  assign tx_bit_ok = (k_tx < len);
  assign rx_bit_ok = (k_rx < len);
  assign tx_idx = sap_pkg::SAMPLE_MSB - k_tx[4:0];
  assign rx_idx = sap_pkg::SAMPLE_MSB - k_rx[4:0];
  assign tx_pop = fall & new_half & is_left;
  assign rx_push = tx_pop & seen_q;
  assign gen_next = gen_slot_q + 6'h01;

  // New left word comes straight from the buffer in its first slot
  always_comb begin
    if (!is_left)
      tx_word = tx_r_q;
    else if (tx_pop)
      tx_word = buf_tx_valid ? buf_tx_data[sap_pkg::PAIR_W-1:
                                           sap_pkg::SAMPLE_W] : '0;
    else
      tx_word = tx_l_q;
  end

  // Pin synchronisers; link levels come from another chip's timing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      b_meta_q <= 1'b0;
      b_sync_q <= 1'b0;
      f_meta_q <= 1'b0;
      f_sync_q <= 1'b0;
      d_meta_q <= 1'b0;
      d_sync_q <= 1'b0;
    end else if (ce) begin
      b_meta_q <= bclk_pin;
      b_sync_q <= b_meta_q;
      f_meta_q <= frame_pin;
      f_sync_q <= f_meta_q;
      d_meta_q <= sdi_pin;
      d_sync_q <= d_meta_q;
    end
  end

  // Clock pins are driven only in master role
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_oe <= 1'b0;
      frame_oe <= 1'b0;
    end else if (ce) begin
      bclk_oe <= master;
      frame_oe <= master;
    end
  end

  // ------------------------------------------------------------------
  // Clock generation
  // ------------------------------------------------------------------
  // 64 bit clocks per frame in every format; frame flips on a fall
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= '0;
      bclk_o <= 1'b0;
      frame_o <= 1'b0;
      gen_slot_q <= sap_pkg::SLOT_LAST;
    end else if (ce && bclk_oe) begin
      if (div_q == sap_pkg::DIV_END) begin
        div_q <= '0;
        bclk_o <= ~bclk_o;
        if (bclk_o) begin
          gen_slot_q <= gen_next;
          frame_o <= gen_next[5] ^ left_lvl;
        end
      end else begin
        div_q <= div_q + 5'h01;
      end
    end
  end

  // Slot counter and frame half bookkeeping, advanced on bit clock falls
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_prev_q <= 1'b0;
      slot_q <= sap_pkg::SLOT_LAST;
      frame_last_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (ce) begin
      bclk_prev_q <= bclk_lvl;
      if (fall) begin
        slot_q <= slot_d;
        frame_last_q <= frame_lvl;
        if (new_half)
          seen_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit and receive shifters
  // ------------------------------------------------------------------
  // Data changes on the fall so the far end samples it on the rise
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_l_q <= '0;
      tx_r_q <= '0;
      sdo_o <= 1'b0;
    end else if (ce) begin
      if (tx_pop) begin
        tx_l_q <= tx_word;
        tx_r_q <= buf_tx_valid ? buf_tx_data[sap_pkg::SAMPLE_W-1:0] : '0;
      end
      if (fall)
        sdo_o <= tx_bit_ok ? tx_word[tx_idx] : 1'b0;
    end
  end

  // Each half's word is cleared at its start so short formats pad zero
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_l_q <= '0;
      rx_r_q <= '0;
    end else if (ce) begin
      if (fall && new_half && is_left)
        rx_l_q <= '0;
      else if (fall && new_half)
        rx_r_q <= '0;
      else if (rise && rx_bit_ok && is_left)
        rx_l_q[rx_idx] <= d_sync_q;
      else if (rise && rx_bit_ok)
        rx_r_q[rx_idx] <= d_sync_q;
    end
  end

  // Audio cannot wait, so a full receive buffer costs the pair
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      rx_overrun <= 1'b0;
    else if (ce)
      rx_overrun <= rx_push & ~rx_in_ready;
  end

  sap_buf2 #(.W(sap_pkg::PAIR_W)) u_tx_buf (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(tx_ready),
    .out_valid(buf_tx_valid),
    .out_data(buf_tx_data),
    .out_ready(tx_pop)
  );

  sap_buf2 #(.W(sap_pkg::PAIR_W)) u_rx_buf (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .in_valid(rx_push),
    .in_data({rx_l_q, rx_r_q}),
    .in_ready(rx_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );
endmodule

// Two-entry buffer; head and tail are flops so every output is registered
module sap_buf2 #(
  parameter int W = 48
) (
  input wire logic mclk, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic in_valid, // Word offered
  input wire logic [W-1:0] in_data, // Offered word
  output logic in_ready, // Room for a word
  output logic out_valid, // Head word present
  output logic [W-1:0] out_data, // Head word
  input wire logic out_ready // Drain takes the head
);
  logic tail_v_q;
  logic [W-1:0] tail_q;
  logic push, pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Ready depends only on the tail, trading one entry for no comb path
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data <= '0;
      tail_v_q <= 1'b0;
      tail_q <= '0;
      in_ready <= 1'b1;
    end else if (ce) begin
      if (pop && tail_v_q) begin
        out_data <= tail_q;
        tail_v_q <= 1'b0;
        in_ready <= 1'b1;
      end else if (pop) begin
        out_valid <= push;
        out_data <= in_data;
      end else if (push && !out_valid) begin
        out_valid <= 1'b1;
        out_data <= in_data;
      end else if (push) begin
        tail_q <= in_data;
        tail_v_q <= 1'b1;
        in_ready <= 1'b0;
      end
    end
  end
endmodule

// Codec end: role strap, register pointer and the framing engine
module sap_device (
  input wire logic mclk, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic master_strap, // Role strap, high for master
  input wire sap_pkg::sap_fmt_t fmt, // Serial format
  input wire logic tx_valid, // Converter pair offered
  input wire logic [sap_pkg::PAIR_W-1:0] tx_data, // Left high
  output logic tx_ready, // Pair accepted
  output logic rx_valid, // Pair from the controller
  output logic [sap_pkg::PAIR_W-1:0] rx_data, // Left high
  input wire logic rx_ready, // Pair consumed
  output logic rx_overrun, // Pulse: pair dropped
  input wire logic ptr_load, // Pulse: load pointer byte
  input wire logic [7:0] ptr_byte, // Pointer byte
  input wire logic byte_done, // Pulse: one register byte moved
  output logic [2:0] reg_pointer_q, // Target register
  output logic pointer_auto_advance_q, // Auto advance enabled
  sap_if.dev link // Serial audio link
);
  logic strap_done_q, master_q;

  // Strap caught on the first enabled edge after reset release
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strap_done_q <= 1'b0;
      master_q <= 1'b0;
    end else if (ce && !strap_done_q) begin
      strap_done_q <= 1'b1;
      master_q <= master_strap;
    end
  end

  // Register pointer; wraps from 7 to 0 during block transfers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_pointer_q <= sap_pkg::PTR_RST;
      pointer_auto_advance_q <= sap_pkg::AUTO_RST;
    end else if (ce) begin
      if (ptr_load) begin
        reg_pointer_q <= ptr_byte[sap_pkg::PTR_MSB:sap_pkg::PTR_LSB];
        pointer_auto_advance_q <= ptr_byte[sap_pkg::PTR_AUTO_POS];
      end else if (byte_done && pointer_auto_advance_q) begin
        reg_pointer_q <= reg_pointer_q + 3'h1;
      end
    end
  end

  sap_engine u_engine (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .master(master_q),
    .fmt(fmt),
    .bclk_pin(link.bit_clock),
    .frame_pin(link.frame_clock),
    .sdi_pin(link.serial_sample_in),
    .bclk_o(link.dev_bclk_o),
    .bclk_oe(link.dev_bclk_oe),
    .frame_o(link.dev_frame_o),
    .frame_oe(link.dev_frame_oe),
    .sdo_o(link.serial_sample_out),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ready(rx_ready),
    .rx_overrun(rx_overrun)
  );
endmodule

// ---- hdl/sap_host.sv ----
// Controller end of the serial audio port
`timescale 1ns/100ps
module sap_host (
  input wire logic mclk, // Core clock, shared with the codec
  input wire logic rst_b, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic host_master, // High when this end drives the clocks
  input wire sap_pkg::sap_fmt_t fmt, // Serial format, same as codec
  input wire logic tx_valid, // Playback pair offered
  input wire logic [sap_pkg::PAIR_W-1:0] tx_data, // Left high
  output logic tx_ready, // Pair accepted
  output logic rx_valid, // Recorded pair available
  output logic [sap_pkg::PAIR_W-1:0] rx_data, // Left high
  input wire logic rx_ready, // Pair consumed
  output logic rx_overrun, // Pulse: pair dropped
  sap_if.host link // Serial audio link
);
  // When this end is master its clocks run at 64 Fs, fit for every format
  sap_engine u_engine (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .master(host_master),
    .fmt(fmt),
    .bclk_pin(link.bit_clock),
    .frame_pin(link.frame_clock),
    .sdi_pin(link.serial_sample_out),
    .bclk_o(link.host_bclk_o),
    .bclk_oe(link.host_bclk_oe),
    .frame_o(link.host_frame_o),
    .frame_oe(link.host_frame_oe),
    .sdo_o(link.serial_sample_in),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ready(rx_ready),
    .rx_overrun(rx_overrun)
  );
endmodule

// ---- testbench/sap_link_asserts.sv ----
// Checker on the shared wires of the serial audio link
`timescale 1ns/100ps
module sap_link_asserts (
  input wire logic mclk, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire sap_pkg::sap_fmt_t fmt, // Serial format
  input wire logic dev_bclk_oe, // Codec drives bit clock
  input wire logic dev_frame_oe, // Codec drives frame clock
  input wire logic host_bclk_oe, // Controller drives bit clock
  input wire logic bit_clock, // Resolved bit clock
  input wire logic frame_clock, // Resolved frame clock
  input wire logic serial_sample_out, // Codec to controller data
  input wire logic serial_sample_in // Controller to codec data
);
  localparam logic [7:0] HALF_END = 8'(sap_pkg::BCLK_HALF_CYC - 1);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  logic bclk_q;
  logic frame_q;
  logic synced_q;
  logic seen_q;
  logic [5:0] slot_q;
  logic [7:0] half_q;
  logic [3:0] age_q;
  logic [5:0] first_slot;
  logic [5:0] end_slot;
  logic fall;
  logic rise;
  logic pad;

  // Bit clock edges and the slots that must carry no sample bit
  assign fall = bclk_q & ~bit_clock;
  assign rise = ~bclk_q & bit_clock;
  assign first_slot = fmt == sap_pkg::SAP_I2S ? 6'h01 :
                      fmt == sap_pkg::SAP_RJ24 ? 6'h08 :
                      fmt == sap_pkg::SAP_RJ20 ? 6'h0C : 6'h00;
  assign end_slot = fmt == sap_pkg::SAP_I2S ? 6'h19 :
                    fmt == sap_pkg::SAP_LJ ? 6'h18 : 6'h20;
  assign pad = synced_q && (slot_q < first_slot || slot_q >= end_slot);

  // Slot count restarts at the fall where the frame clock moved
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_q <= 1'b0;
      frame_q <= 1'b0;
      synced_q <= 1'b0;
      slot_q <= 6'h00;
    end else begin
      bclk_q <= bit_clock;
      if (fall) begin
        frame_q <= frame_clock;
        synced_q <= synced_q | (frame_clock != frame_q);
        slot_q <= (frame_clock != frame_q) ? 6'h00 : slot_q + 6'h01;
      end
    end
  end

  // Saturating ages; the first toggle is ignored since its phase is free
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      half_q <= 8'h00;
      seen_q <= 1'b0;
      age_q <= 4'h0;
    end else begin
      half_q <= (bclk_q != bit_clock) ? 8'h00 :
                half_q + {7'h00, half_q != 8'hFF};
      seen_q <= seen_q | (bclk_q != bit_clock);
      age_q <= fall ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
    end
  end

  chk_bclk_half_period: assert property (
    (bclk_q != bit_clock) && seen_q |-> half_q == HALF_END)
    else $error("bit clock half period wrong");
  chk_frame_half_slots: assert property (
    fall && synced_q && frame_clock != frame_q |-> slot_q == 6'h1F)
    else $error("frame half is not 32 bits");
  chk_pad_out_zero: assert property (
    rise && pad |-> !serial_sample_out)
    else $error("codec data outside sample slots");
  chk_pad_in_zero: assert property (
    rise && pad |-> !serial_sample_in)
    else $error("controller data outside sample slots");
  chk_one_clock_owner: assert property (
    !(dev_bclk_oe && host_bclk_oe))
    else $error("both ends drive the bit clock");
  chk_dev_oe_pair: assert property (
    dev_bclk_oe == dev_frame_oe)
    else $error("codec clock enables differ");
  chk_data_after_fall: assert property (
    $changed(serial_sample_out) |-> age_q <= 4'h5)
    else $error("codec data moved away from a fall");
  chk_frame_at_low: assert property (
    $changed(frame_clock) |-> (!bit_clock) [*8])
    else $error("frame clock moved with bit clock high");

  // Main scenarios reached
  cover property (fall && synced_q && fmt == sap_pkg::SAP_RJ20);
  cover property (host_bclk_oe && rise);
  cover property (rise && !pad && serial_sample_out);
endmodule

// ---- testbench/stereo_audio_serial_port_test.sv ----
// Bench joining the codec end and the controller end over one link
`timescale 1ns/100ps
module stereo_audio_serial_port_test;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  sap_pkg::sap_fmt_t fmt = sap_pkg::SAP_I2S;
  logic dm = 1'b1;
  logic d_txv = 1'b0;
  logic h_txv = 1'b0;
  logic [47:0] d_txd = 48'h0;
  logic [47:0] h_txd = 48'h0;
  logic h_rxr = 1'b1;
  logic ptr_load = 1'b0;
  logic [7:0] ptr_byte = 8'h00;
  logic byte_done = 1'b0;
  logic d_txr, h_txr, d_rxv, h_rxv, h_ovr, aut;
  logic [47:0] d_rxd, h_rxd;
  logic [2:0] ptr;
  int n_mismatch = 0;
  int num_checks = 0;

  // 125 MHz core clock
  always #4 mclk = ~mclk;

  sap_if sap_if_i ();
  sap_device sap_device_i (
    .mclk(mclk), .rst_b(rst_b), .ce(1'b1), .master_strap(dm), .fmt(fmt),
    .tx_valid(d_txv), .tx_data(d_txd), .tx_ready(d_txr), .rx_valid(d_rxv),
    .rx_data(d_rxd), .rx_ready(1'b1), .rx_overrun(),
    .ptr_load(ptr_load), .ptr_byte(ptr_byte), .byte_done(byte_done),
    .reg_pointer_q(ptr), .pointer_auto_advance_q(aut), .link(sap_if_i)
  );
  sap_host sap_host_i (
    .mclk(mclk), .rst_b(rst_b), .ce(1'b1), .host_master(!dm), .fmt(fmt),
    .tx_valid(h_txv), .tx_data(h_txd), .tx_ready(h_txr), .rx_valid(h_rxv),
    .rx_data(h_rxd), .rx_ready(h_rxr), .rx_overrun(h_ovr), .link(sap_if_i)
  );
  sap_link_asserts sap_link_asserts_i (
    .mclk(mclk), .rst_b(rst_b), .fmt(fmt),
    .dev_bclk_oe(sap_if_i.dev_bclk_oe), .dev_frame_oe(sap_if_i.dev_frame_oe),
    .host_bclk_oe(sap_if_i.host_bclk_oe), .bit_clock(sap_if_i.bit_clock),
    .frame_clock(sap_if_i.frame_clock),
    .serial_sample_out(sap_if_i.serial_sample_out),
    .serial_sample_in(sap_if_i.serial_sample_in)
  );

  // Pair sent by each end; low nibbles vanish in the 20-bit format
  function automatic logic [47:0] pval(input bit s, input int i);
    return (s ? 48'hC6A5F3E1D2B7 : 48'h9A1B2C3D4E5F) +
           48'h010101010101 * 48'(i);
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [47:0] got, input logic [47:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t ns: %s got %h", $time, what, got);
    end
  endtask

  // A wait that used up its bound ends the run
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      n_mismatch++;
      $display("unexpected at %0t ns: wait ran out", $time);
      wrap_up();
    end
  endtask

  // Offer pairs only while ready is high, so none is taken twice
  task automatic send(input bit s, input int from, input int to);
    int k;
    for (int i = from; i < to; i++) begin
      k = 0;
      while ((s ? h_txr : d_txr) !== 1'b1 && k < 20000) begin
        if (s) h_txv = 1'b0; else d_txv = 1'b0;
        @(negedge mclk);
        k++;
      end
      tmo(k, 20000);
      if (s) h_txd = pval(s, i); else d_txd = pval(s, i);
      if (s) h_txv = 1'b1; else d_txv = 1'b1;
      @(negedge mclk);
    end
    if (s) h_txv = 1'b0; else d_txv = 1'b0;
  endtask

  // Leading zero frames are underrun fill; hold stalls after one pair
  task automatic recv(input bit s, input bit hold);
    int k;
    int i;
    logic [47:0] got;
    k = 0;
    i = 0;
    while (i < 3 && k < 20000) begin
      got = s ? h_rxd : d_rxd;
      if ((s ? h_rxv : d_rxv) === 1'b1 && (i > 0 || got !== 48'h0)) begin
        check(got, pval(!s, i) & (fmt == sap_pkg::SAP_RJ20 ?
              48'hFFFFF0FFFFF0 : 48'hFFFFFFFFFFFF), "pair");
        i++;
        if (hold && i == 1) begin
          @(negedge mclk);
          h_rxr = 1'b0;
          while (h_ovr !== 1'b1 && k < 20000) begin
            @(negedge mclk);
            k++;
          end
          h_rxr = 1'b1;
          continue;
        end
      end
      @(negedge mclk);
      k++;
    end
    tmo(k, 20000);
  endtask

  // One full frame on the wire and who owns the clocks
  task automatic meas;
    int k;
    int n;
    int t0;
    logic p;
    k = 0;
    n = 0;
    t0 = 0;
    p = sap_if_i.frame_clock;
    while (n < 2 && k < 9000) begin
      @(negedge mclk);
      k++;
      // Mark the start before counting, so the span is one frame exactly
      if (n == 0) t0 = k;
      if (sap_if_i.frame_clock === 1'b1 && p === 1'b0) n++;
      p = sap_if_i.frame_clock;
    end
    tmo(k, 9000);
    check(48'(k - t0), 48'(128 * sap_pkg::BCLK_HALF_CYC), "frame");
    check(48'(sap_if_i.dev_bclk_oe), 48'(dm), "clock owner");
  endtask

  task automatic pstep(input bit ld, input logic [7:0] b,
                       input logic [3:0] exp);
    ptr_load = ld;
    byte_done = !ld;
    ptr_byte = b;
    @(negedge mclk);
    ptr_load = 1'b0;
    byte_done = 1'b0;
    @(negedge mclk);
    check(48'({aut, ptr}), 48'(exp), "pointer");
  endtask

  task automatic run(input sap_pkg::sap_fmt_t f, input logic m,
                     input bit hold);
    @(negedge mclk);
    rst_b = 1'b0;
    fmt = f;
    dm = m;
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    check(48'(d_txr), 48'h1, "ready after reset");
    fork
      begin
        send(1'b0, 0, 2);
        repeat (2) @(negedge mclk);
        check(48'(d_txr), 48'h0, "buffer full");
        send(1'b0, 2, 3);
      end
      send(1'b1, 0, 3);
      recv(1'b0, 1'b0);
      recv(1'b1, hold);
      meas();
    join
    $display("test format %0d master %0d done", f, m);
  endtask

  // Main sequence: every format with the codec as master, then I2S with the controller as master
  initial begin
    run(sap_pkg::SAP_I2S, 1'b1, 1'b1);
    check(48'({aut, ptr}), 48'h0, "pointer reset");
    pstep(1'b1, 8'h83, 4'hB);
    pstep(1'b0, 8'h00, 4'hC);
    pstep(1'b1, 8'h07, 4'h7);
    pstep(1'b0, 8'h00, 4'h7);
    pstep(1'b1, 8'h87, 4'hF);
    pstep(1'b0, 8'h00, 4'h8);
    $display("test pointer done");
    run(sap_pkg::SAP_LJ, 1'b1, 1'b0);
    run(sap_pkg::SAP_RJ24, 1'b1, 1'b0);
    run(sap_pkg::SAP_RJ20, 1'b1, 1'b0);
    run(sap_pkg::SAP_I2S, 1'b0, 1'b0);
    wrap_up();
  end
endmodule
